/* File: hw/dcs_channel_status.sv */
// Status, interrupt enable and processor-bus attribute logic for four DMA channels.
// Assumes the transfer engine pulses event inputs for one cycle and honours channelMayStart.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RULE_01) Sticky processor-bus error flag, write-one clears
// (RULE_02) Sticky stopped flag, write-one clears
// (RULE_03) Sticky halted flag, write-one clears
// (RULE_04) Done sets on direct or linked completion
// (RULE_05) No new transfer while any flag set
// (RULE_06) Done reads zero until completion, resets zero
// (RULE_07) PCI port one error interrupt enable
// (RULE_08) PCI port two error interrupt enable
// (RULE_09) Processor-bus error interrupt enable
// (RULE_10) Stopped interrupt enable
// (RULE_11) Halted interrupt enable
// (RULE_12) Done interrupt enable
// (RULE_13) Per-channel attributes, only register writes load
// (RULE_14) Two-bit command packet fetch port select
// (RULE_15) Global line asserted when bit is zero
// (RULE_16) Cache-inhibit asserted when bit is zero
// (RULE_17) Read transfer type, reset 01010
// (RULE_18) Write transfer type, reset 00010
// (RULE_19) Field bit four drives line zero
// (RULE_20) Sticky PCI port error flags, write-one clears
// (RULE_21) Interrupt while flag and enable both set
module dcs_channel_status
  import dcs_pkg::*;
#(
  parameter bit DUAL_PCI = 1'b1
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rst_n,
  input  wire logic [11:0]                        regAddr,
  input  wire logic [31:0]                        regWrData,
  input  wire logic                               regWrStrobe,
  input  wire logic                               regRdStrobe,
  output logic      [31:0]                        regRdData,
  input  wire logic [DCS_CHANNELS-1:0]            pciPort1ErrorEvent,
  input  wire logic [DCS_CHANNELS-1:0]            pciPort2ErrorEvent,
  input  wire logic [DCS_CHANNELS-1:0]            procBusErrorEvent,
  input  wire logic [DCS_CHANNELS-1:0]            stoppedEvent,
  input  wire logic [DCS_CHANNELS-1:0]            haltedEvent,
  input  wire logic [DCS_CHANNELS-1:0]            directDoneEvent,
  input  wire logic [DCS_CHANNELS-1:0]            linkedDoneEvent,
  input  wire logic [DCS_CHANNELS-1:0]            transferIsWrite,
  output logic      [DCS_CHANNELS-1:0]            channelMayStart,
  output logic      [DCS_CHANNELS-1:0]            channelIrq,
  output logic      [DCS_CHANNELS-1:0][1:0]       commandFetchPortSelect,
  output logic      [DCS_CHANNELS-1:0]            procBusGlobalLine_n,
  output logic      [DCS_CHANNELS-1:0]            procBusCacheInhibitLine_n,
  output logic      [DCS_CHANNELS-1:0][0:4]       procBusTransferTypeLines
);

  dcs_flags_t [DCS_CHANNELS-1:0] flags_q;
  dcs_flags_t [DCS_CHANNELS-1:0] enables_q;
  dcs_attr_t  [DCS_CHANNELS-1:0] attr_q;
  logic       [31:0]             regRdData_q;
  logic       [DCS_CHANNELS-1:0][5:0] flagClr;
  logic       [DCS_CHANNELS-1:0][5:0] flagSet;

  // Valid flag bits; port two is reserved on single-PCI parts
  localparam logic [5:0] FLAG_MASK = DUAL_PCI ? 6'h3f : 6'h2f;

  function automatic logic [11:0] statOffset(input int ch);
    statOffset = DCS_STAT_OFF0 + 12'(ch) * DCS_CHAN_STRIDE;
  endfunction : statOffset

  function automatic logic [11:0] attrOffset(input int ch);
    case (ch)
      0:       attrOffset = DCS_ATTR_OFF0;
      1:       attrOffset = DCS_ATTR_OFF1;
      2:       attrOffset = DCS_ATTR_OFF2;
      default: attrOffset = DCS_ATTR_OFF3;
    endcase
  endfunction : attrOffset

  // Write-one-clear mask and event set vector per channel
  always_comb begin
    for (int ch = 0; ch < DCS_CHANNELS; ch++) begin
      flagClr[ch] = (regWrStrobe && regAddr == statOffset(ch))
                    ? regWrData[DCS_STAT_POS +: DCS_FLAG_W] : 6'h00; // see (RULE_01) see (RULE_02) see (RULE_03)
      flagSet[ch] = {pciPort1ErrorEvent[ch], pciPort2ErrorEvent[ch], // see (RULE_20)
                     procBusErrorEvent[ch], stoppedEvent[ch], haltedEvent[ch],
                     directDoneEvent[ch] | linkedDoneEvent[ch]}; // see (RULE_04)
    end
  end

  // Sticky status flags; a new event in the clear cycle wins
  always_ff @(posedge sys_clk) begin
    for (int ch = 0; ch < DCS_CHANNELS; ch++) begin
      if (!rst_n) begin
        flags_q[ch] <= DCS_FLAG_RST; // see (RULE_06)
      end else begin
        flags_q[ch] <= ((flags_q[ch] & ~flagClr[ch]) | flagSet[ch]) & FLAG_MASK;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge sys_clk) begin
    for (int ch = 0; ch < DCS_CHANNELS; ch++) begin
      if (!rst_n) begin
        enables_q[ch] <= DCS_FLAG_RST;
      end else if (regWrStrobe && regAddr == statOffset(ch)) begin
        enables_q[ch] <= regWrData[DCS_EN_POS +: DCS_FLAG_W] & FLAG_MASK; // see (RULE_07) see (RULE_08) see (RULE_09)
      end
    end
  end

  // Attribute registers, loaded only by direct register writes
  always_ff @(posedge sys_clk) begin
    for (int ch = 0; ch < DCS_CHANNELS; ch++) begin
      if (!rst_n) begin
        attr_q[ch] <= '{DCS_PORT_RST, 1'b0, 1'b0, DCS_RTT_RST, DCS_WTT_RST}; // see (RULE_17) see (RULE_18)
      end else if (regWrStrobe && regAddr == attrOffset(ch)) begin // see (RULE_13)
        attr_q[ch].commandFetchPortSelect  <= regWrData[DCS_PORT_POS +: 2]; // see (RULE_14)
        attr_q[ch].procBusGlobalLine       <= regWrData[DCS_GBL_POS];
        attr_q[ch].procBusCacheInhibitLine <= regWrData[DCS_CI_POS];
        attr_q[ch].readTransferTypeField   <= regWrData[DCS_RTT_POS +: 5];
        attr_q[ch].writeTransferTypeField  <= regWrData[DCS_WTT_POS +: 5];
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData_q <= 32'h0000_0000;
    end else begin
      regRdData_q <= 32'h0000_0000;
      if (regRdStrobe) begin
        for (int ch = 0; ch < DCS_CHANNELS; ch++) begin
          if (regAddr == statOffset(ch)) begin
            regRdData_q <= 32'({flags_q[ch], 2'b00, enables_q[ch]});
          end
          if (regAddr == attrOffset(ch)) begin
            regRdData_q <= {attr_q[ch].commandFetchPortSelect, 2'b00,
                            attr_q[ch].procBusGlobalLine, attr_q[ch].procBusCacheInhibitLine,
                            5'h00, attr_q[ch].readTransferTypeField,
                            3'b000, attr_q[ch].writeTransferTypeField, 8'h00};
          end
        end
      end
    end
  end

  assign regRdData = regRdData_q;

  always_comb begin
    for (int ch = 0; ch < DCS_CHANNELS; ch++) begin
      channelMayStart[ch]           = (flags_q[ch] == DCS_FLAG_RST);    // see (RULE_05)
      channelIrq[ch]                = |(flags_q[ch] & enables_q[ch]);   // see (RULE_10) see (RULE_11) see (RULE_12) see (RULE_21)
      commandFetchPortSelect[ch]    = attr_q[ch].commandFetchPortSelect;
      procBusGlobalLine_n[ch]       = attr_q[ch].procBusGlobalLine;       // see (RULE_15)
      procBusCacheInhibitLine_n[ch] = attr_q[ch].procBusCacheInhibitLine; // see (RULE_16)
      // Packed [0:4] means field bit 4 lands on line 0
      procBusTransferTypeLines[ch]  = transferIsWrite[ch] ? attr_q[ch].writeTransferTypeField
                                                          : attr_q[ch].readTransferTypeField; // see (RULE_19)
    end
  end

endmodule : dcs_channel_status

`default_nettype wire

/* File: hw/dcs_pkg.sv */
// Package for the DMA channel status and attribute block.
// Assumes one 20 MHz clock and a plain register port with byte addresses.
package dcs_pkg;

  localparam int          DCS_CHANNELS      = 4;
  localparam logic [11:0] DCS_ATTR_OFF0     = 12'h324;
  localparam logic [11:0] DCS_ATTR_OFF1     = 12'h354;
  localparam logic [11:0] DCS_ATTR_OFF2     = 12'h384;
  localparam logic [11:0] DCS_ATTR_OFF3     = 12'h3b4;
  localparam logic [11:0] DCS_STAT_OFF0     = 12'h320;
  localparam logic [11:0] DCS_CHAN_STRIDE   = 12'h030;

  // Status/enable register layout
  localparam int DCS_STAT_DONE_POS    = 8;
  localparam int DCS_STAT_POS         = 8;
  localparam int DCS_EN_POS           = 0;
  localparam int DCS_FLAG_W           = 6;

  // Attribute register layout
  localparam int DCS_PORT_POS = 30;
  localparam int DCS_GBL_POS  = 27;
  localparam int DCS_CI_POS   = 26;
  localparam int DCS_RTT_POS  = 16;
  localparam int DCS_WTT_POS  = 8;

  localparam logic [1:0] DCS_PORT_RST = 2'h0;
  localparam logic [4:0] DCS_RTT_RST  = 5'h0a;
  localparam logic [4:0] DCS_WTT_RST  = 5'h02;
  localparam logic [5:0] DCS_FLAG_RST = 6'h00;

  typedef enum logic [1:0] {
    DCS_FETCH_PCI1 = 2'h0,
    DCS_FETCH_PCI2 = 2'h1,
    DCS_FETCH_PB   = 2'h2,
    DCS_FETCH_RSVD = 2'h3
  } dcs_fetch_port_t;

  // Flags ordered pci1, pci2, pb, stop, halt, done (bit 5 down to bit 0)
  typedef struct packed {
    logic pciPort1Error;
    logic pciPort2Error;
    logic procBusError;
    logic stopped;
    logic halted;
    logic done;
  } dcs_flags_t;

  typedef struct packed {
    logic [1:0] commandFetchPortSelect;
    logic       procBusGlobalLine;
    logic       procBusCacheInhibitLine;
    logic [4:0] readTransferTypeField;
    logic [4:0] writeTransferTypeField;
  } dcs_attr_t;

endpackage : dcs_pkg

/* File: tb/dcs_engine_model.sv */
// Transfer engine model: one event pulse per start request.
// Assumes one-cycle go pulses from the testbench.
`timescale 1ns/1ps
`default_nettype none
module dcs_engine_model (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic [3:0]      go,
  input  wire logic [2:0]      kind,
  input  wire logic [3:0]      channelMayStart,
  output logic      [6:0][3:0] ev
);
  // Starts only channels whose flags are all clear
  always_ff @(posedge sys_clk) begin
    ev <= '0;
    if (rst_n) ev[kind] <= go & channelMayStart;
  end
endmodule : dcs_engine_model
`default_nettype wire

/* File: tb/dcs_chk.sv */
// Checker: port-level assertions, watching channel 0; the reset checks on start, irq, fetch port select and global line outputs cover all four channels.
// Assumes binding into dcs_channel_status, one clock.
`timescale 1ns/1ps
`default_nettype none
module dcs_chk
  import dcs_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            rst_n,
  input wire logic [11:0]     regAddr,
  input wire logic            regWrStrobe,
  input wire logic [3:0]      pciPort1ErrorEvent,
  input wire logic [3:0]      procBusErrorEvent,
  input wire logic [3:0]      stoppedEvent,
  input wire logic [3:0]      directDoneEvent,
  input wire logic [3:0]      linkedDoneEvent,
  input wire logic [3:0]      transferIsWrite,
  input wire logic [3:0]      channelMayStart,
  input wire logic [3:0]      channelIrq,
  input wire logic [3:0][1:0] commandFetchPortSelect,
  input wire logic [3:0]      procBusGlobalLine_n,
  input wire logic [3:0][0:4] procBusTransferTypeLines
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_attrRst; $rose(rst_n) |-> commandFetchPortSelect == '0 && procBusGlobalLine_n == '0; endproperty
  a_attrRst: assert property (p_attrRst) else $error("attribute outputs off reset value");
  property p_ttRst; $rose(rst_n) |-> procBusTransferTypeLines[0] == (transferIsWrite[0] ? 5'h02 : 5'h0a); endproperty
  a_ttRst: assert property (p_ttRst) else $error("transfer type lines off reset value");
  property p_runRst; $rose(rst_n) |-> channelMayStart == 4'hf && channelIrq == 4'h0; endproperty
  a_runRst: assert property (p_runRst) else $error("start or irq off reset value");
  property p_doneSet; directDoneEvent[0] || linkedDoneEvent[0] |=> !channelMayStart[0]; endproperty
  a_doneSet: assert property (p_doneSet) else $error("done did not block start");
  property p_errSet; procBusErrorEvent[0] || stoppedEvent[0] || pciPort1ErrorEvent[0] |=> !channelMayStart[0]; endproperty
  a_errSet: assert property (p_errSet) else $error("flag did not block start");
  property p_sticky; $rose(channelMayStart[0]) |-> $past(regWrStrobe && regAddr == DCS_STAT_OFF0) || !$past(rst_n); endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared without write");
  property p_irqFall; $fell(channelIrq[0]) |-> $past(regWrStrobe) || !$past(rst_n); endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq fell without write");
  property p_attrHold; !$stable(commandFetchPortSelect[0]) |-> $past(regWrStrobe && regAddr == DCS_ATTR_OFF0) || !$past(rst_n); endproperty
  a_attrHold: assert property (p_attrHold) else $error("attribute changed without write");
  c_doneIrq: cover property (directDoneEvent[0] ##1 channelIrq[0]);
  c_clear: cover property ($rose(channelMayStart[0]));
  c_attrWr: cover property (regWrStrobe && regAddr == DCS_ATTR_OFF0);
endmodule : dcs_chk
bind dcs_channel_status dcs_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrStrobe(regWrStrobe),
  .pciPort1ErrorEvent(pciPort1ErrorEvent), .procBusErrorEvent(procBusErrorEvent), .stoppedEvent(stoppedEvent),
  .directDoneEvent(directDoneEvent), .linkedDoneEvent(linkedDoneEvent), .transferIsWrite(transferIsWrite),
  .channelMayStart(channelMayStart), .channelIrq(channelIrq), .commandFetchPortSelect(commandFetchPortSelect),
  .procBusGlobalLine_n(procBusGlobalLine_n), .procBusTransferTypeLines(procBusTransferTypeLines));
`default_nettype wire

/* File: tb/tb_dma_channel_status_and_attributes.sv */
// Testbench: reset values, event flags, interrupt masking, attribute outputs.
// Assumes the engine model drives the event inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_status_and_attributes
  import dcs_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, regWrStrobe = 1'b0, regRdStrobe = 1'b0, rdSeen = 1'b0;
  logic [11:0] regAddr = '0;
  logic [31:0] regWrData = '0, regRdData, r, expQ[$];
  logic [3:0] go = '0, transferIsWrite = '0, channelMayStart, channelIrq, pbGbl, pbCi;
  logic [3:0][1:0] portSel;
  logic [3:0][0:4] ttLines;
  logic [2:0] kind = '0;
  logic [6:0][3:0] ev;
  int n_mismatch = 0, check_count = 0, seed = 32'he1f9, ch, f;
  initial forever #25 sys_clk = ~sys_clk;
  dcs_engine_model eng (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .kind(kind), .channelMayStart(channelMayStart),
    .ev(ev));
  dcs_channel_status dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData), .pciPort1ErrorEvent(ev[0]),
    .pciPort2ErrorEvent(ev[1]), .procBusErrorEvent(ev[2]), .stoppedEvent(ev[3]), .haltedEvent(ev[4]),
    .directDoneEvent(ev[5]), .linkedDoneEvent(ev[6]), .transferIsWrite(transferIsWrite),
    .channelMayStart(channelMayStart), .channelIrq(channelIrq), .commandFetchPortSelect(portSel),
    .procBusGlobalLine_n(pbGbl), .procBusCacheInhibitLine_n(pbCi), .procBusTransferTypeLines(ttLines));
  function automatic logic [11:0] off(input int n, input logic [11:0] b);
    return b + 12'(n) * DCS_CHAN_STRIDE;
  endfunction : off
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task bus(input bit w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= w;
    regRdStrobe <= !w;
    if (!w) expQ.push_back(d);
    @(posedge sys_clk);
    regWrStrobe <= 1'b0;
    regRdStrobe <= 1'b0;
  endtask : bus
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Read data stand one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rdSeen) chk("regRdData", expQ.pop_front(), regRdData);
    else if (rst_n) chk("regRdIdle", 32'h0, regRdData);
    rdSeen <= regRdStrobe;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      bus(0, off(n, DCS_ATTR_OFF0), 32'h000a0200);
      bus(0, off(n, DCS_STAT_OFF0), 32'h0);
    end
    bus(0, 12'h3f0, 32'h0);
    // Each event kind with its own enable off, then only its own enable on
    for (int k = 0; k < 7; k++) begin
      ch = (k == 0 || k == 5) ? 0 : {$random(seed)} % 4;
      f = (k < 6) ? 5 - k : 0;
      for (int p = 0; p < 2; p++) begin
        r = p ? (32'h1 << f) : (32'h3f ^ (32'h1 << f));
        bus(1, off(ch, DCS_STAT_OFF0), r);
        kind <= 3'(k);
        go[ch] <= 1'b1;
        @(posedge sys_clk);
        go <= '0;
        repeat (2) @(posedge sys_clk);
        chk("channelIrq", 32'(p), 32'(channelIrq[ch]));
        chk("channelMayStart", 32'h0, 32'(channelMayStart[ch]));
        bus(1, off(ch, DCS_STAT_OFF0), r);
        bus(0, off(ch, DCS_STAT_OFF0), r | (32'h100 << f));
        bus(1, off(ch, DCS_STAT_OFF0), r | (32'h100 << f));
        bus(0, off(ch, DCS_STAT_OFF0), r);
        chk("channelIrq", 32'h0, 32'(channelIrq[ch]));
      end
    end
    for (int n = 0; n < 4; n++) begin
      r = $random(seed);
      transferIsWrite <= 4'($random(seed));
      bus(1, off(n, DCS_ATTR_OFF0), r);
      bus(0, off(n, DCS_ATTR_OFF0), r & 32'hcc1f1f00);
      chk("portSel", 32'(r[31:30]), 32'(portSel[n]));
      chk("global", 32'(r[27]), 32'(pbGbl[n]));
      chk("cacheInhibit", 32'(r[26]), 32'(pbCi[n]));
      chk("ttLines", 32'(transferIsWrite[n] ? r[12:8] : r[20:16]), 32'(ttLines[n]));
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, off(3, DCS_ATTR_OFF0), 32'h000a0200);
    repeat (2) @(posedge sys_clk);
    chk("pendingReads", 32'h0, 32'(expQ.size()));
    complete_run();
  end
endmodule : tb_dma_channel_status_and_attributes
`default_nettype wire
